// File: lcdw_defines.svh
`ifndef LCDW_DEFINES_SVH
`define LCDW_DEFINES_SVH
`define LCDW_RAM_WORDS 40
`define LCDW_RAM_LAST 6'h27
`define LCDW_MODE_STATIC 2'h1
`define LCDW_MODE_MUX2 2'h2
`define LCDW_MODE_MUX3 2'h3
`define LCDW_MODE_MUX4 2'h0
`define LCDW_BPG_STATIC 3'h1
`define LCDW_BPG_MUX2 3'h2
`define LCDW_BPG_MUX3 3'h3
`define LCDW_BPG_MUX4 3'h4
`define LCDW_ALT_BASE 2'h2
`define LCDW_BYTE_BITS 4'h8
`define LCDW_BIT_LAST 4'h7
`define LCDW_ACK_WAIT 4'h8
`define LCDW_ACK_DRIVE 4'h9
`define LCDW_BLINK_DIV1 12'h300
`define LCDW_BLINK_DIV2 12'h600
`define LCDW_BLINK_DIV3 12'hc00
`define LCDW_SLAVE_HI 6'h1c
`define LCDW_OP_MODE 2'h2
`define LCDW_OP_DEV 4'hc
`define LCDW_OP_BANK 5'h1e
`define LCDW_OP_BLINK 4'he
`define LCDW_PIN_RST 6'h03
`define LCDW_CFG_RST 4'h0
`endif

// File: lcdw_pkg.sv
package lcdw_pkg;
  typedef struct packed {
    logic en;
    logic bias;
    logic [1:0] mode;
  } lcdw_cfg_s;
  typedef struct packed {
    logic alt;
    logic [1:0] rate;
  } lcdw_blink_s;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_SKIP}
    lcdw_state_e;
endpackage

// File: lcdw_top.sv
`timescale 1ns/100ps
`include "lcdw_defines.svh"
// Behaviour
// - display bytes go where RAM index points
// - index step follows drive mode groups
// - store only when subaddress counter matches straps
// - mismatch: no write, index still advances
// - index overflow bumps subaddress counter
// - output row follows multiplex sequence
// - output bank picks rows two/three in static/1:2
// - input bank picks rows two/three independently in static/1:2
// - blink divides core clock 768/1536/3072
// - alternate blink swaps banks static/1:2
// - one bit per clock, data stable high
// - start and stop while clock high
// - eight bits then one acknowledge clock
// - acknowledge held low through ack clock
// - only output is acknowledge pull-down
// - selection from address, commands, straps
// - six-bit index loads 0 to 63, only 0 to 39 written
// - three-bit subaddress loads 0 to 7
// - static byte fills row of eight words
module lcdw_top
  import lcdw_pkg::*;
#(
  parameter int MUX_DIV = 64
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sa0_strap,
  input wire logic strap_sub_bit0,
  input wire logic strap_sub_bit1,
  input wire logic strap_sub_bit2,
  output logic [`LCDW_RAM_WORDS-1:0] seg_data,
  output logic [1:0] bp_sel,
  output logic disp_on,
  output lcdw_cfg_s drive_cfg,
  output logic [5:0] ram_ptr,
  output logic [2:0] sub_cnt
);

default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_n);

////////////////////////////////////////////////////////////////////////////
// pin synchronisers: a bit changes once stages two and three agree
logic [5:0] pin_raw;
logic [5:0] s1_reg, s2_reg, s3_reg, pin_reg;
logic [5:0] agree;
logic sda_f, scl_f, sda_d_reg, scl_d_reg, sa0_f;
logic [2:0] strap_sub;

assign pin_raw = {sa0_strap, strap_sub_bit2, strap_sub_bit1,
                  strap_sub_bit0, scl_in, sda_in};
assign agree = ~(s2_reg ^ s3_reg);

always_ff @(posedge sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    s1_reg <= `LCDW_PIN_RST;
    s2_reg <= `LCDW_PIN_RST;
    s3_reg <= `LCDW_PIN_RST;
    pin_reg <= `LCDW_PIN_RST;
    sda_d_reg <= 1'b1;
    scl_d_reg <= 1'b1;
  end else begin
    s1_reg <= pin_raw;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    pin_reg <= (agree & s2_reg) | (~agree & pin_reg);
    sda_d_reg <= sda_f;
    scl_d_reg <= scl_f;
  end
end

assign sda_f = pin_reg[0];
assign scl_f = pin_reg[1];
// straps are trusted steady for the length of an access
assign strap_sub = pin_reg[4:2];
assign sa0_f = pin_reg[5];

////////////////////////////////////////////////////////////////////////////
// serial receiver
logic scl_rise, scl_fall, start_det, stop_det, byte_done;
logic [7:0] rx_byte;
logic [7:0] shift_reg;
logic [3:0] bit_cnt_reg;
logic ack_want_reg, ack_oe_reg;
lcdw_state_e state_reg;
logic cmd_take, data_take, sub_match;

assign scl_rise = scl_f & ~scl_d_reg;
assign scl_fall = ~scl_f & scl_d_reg;
assign start_det = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
assign stop_det = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
assign byte_done = scl_rise & (bit_cnt_reg == `LCDW_BIT_LAST);
assign rx_byte = {shift_reg[6:0], sda_f};
assign cmd_take = byte_done & (state_reg == ST_CMD);
assign data_take = byte_done & (state_reg == ST_DATA);

always_ff @(posedge sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    shift_reg <= 8'h00;
    bit_cnt_reg <= 4'h0;
  end else if (start_det || stop_det) begin
    bit_cnt_reg <= 4'h0;
  end else if (scl_rise && bit_cnt_reg < `LCDW_BYTE_BITS) begin
    shift_reg <= rx_byte;
    bit_cnt_reg <= bit_cnt_reg + 4'h1;
  end else if (scl_fall && bit_cnt_reg == `LCDW_ACK_WAIT) begin
    bit_cnt_reg <= `LCDW_ACK_DRIVE;
  end else if (scl_fall && bit_cnt_reg == `LCDW_ACK_DRIVE) begin
    bit_cnt_reg <= 4'h0;
  end
end

// a read request or a foreign address is skipped until the next start
always_ff @(posedge sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    state_reg <= ST_IDLE;
    ack_want_reg <= 1'b0;
  end else if (start_det) begin
    state_reg <= ST_ADDR;
    ack_want_reg <= 1'b0;
  end else if (stop_det) begin
    state_reg <= ST_IDLE;
    ack_want_reg <= 1'b0;
  end else if (byte_done) begin
    case (state_reg)
      ST_ADDR: begin
        if (rx_byte[7:1] == {`LCDW_SLAVE_HI, sa0_f} && !rx_byte[0]) begin
          state_reg <= ST_CMD;
          ack_want_reg <= 1'b1;
        end else begin
          state_reg <= ST_SKIP;
          ack_want_reg <= 1'b0;
        end
      end
      ST_CMD: begin
        state_reg <= rx_byte[7] ? ST_CMD : ST_DATA;
        ack_want_reg <= 1'b1;
      end
      ST_DATA: ack_want_reg <= sub_match;
      default: ack_want_reg <= 1'b0;
    endcase
  end
end

// pull-down starts after the eighth bit and lasts to the ack clock's fall
always_ff @(posedge sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    ack_oe_reg <= 1'b0;
  end else if (start_det || stop_det) begin
    ack_oe_reg <= 1'b0;
  end else if (scl_fall && bit_cnt_reg == `LCDW_ACK_WAIT) begin
    ack_oe_reg <= ack_want_reg;
  end else if (scl_fall && bit_cnt_reg == `LCDW_ACK_DRIVE) begin
    ack_oe_reg <= 1'b0;
  end
end

assign sda_out = 1'b0;
assign sda_oe = ack_oe_reg;

////////////////////////////////////////////////////////////////////////////
// command decode
lcdw_cfg_s cfg_reg;
lcdw_blink_s blink_reg;
logic in_bank_reg, out_bank_reg;

always_ff @(posedge sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    cfg_reg <= `LCDW_CFG_RST;
    blink_reg <= 3'h0;
    in_bank_reg <= 1'b0;
    out_bank_reg <= 1'b0;
  end else if (cmd_take) begin
    if (rx_byte[6:5] == `LCDW_OP_MODE) begin
      cfg_reg <= rx_byte[3:0];
    end else if (rx_byte[6:2] == `LCDW_OP_BANK) begin
      in_bank_reg <= rx_byte[1];
      out_bank_reg <= rx_byte[0];
    end else if (rx_byte[6:3] == `LCDW_OP_BLINK) begin
      blink_reg <= rx_byte[2:0];
    end
  end
end

assign drive_cfg = cfg_reg;

////////////////////////////////////////////////////////////////////////////
// write sequencer: one RAM word per cycle, each word a bit group
logic [3:0] ram_reg [0:`LCDW_RAM_WORDS-1];
logic [5:0] ptr_reg;
logic [2:0] sub_cnt_reg;
logic [7:0] seq_sh_reg;
logic [3:0] seq_bits_reg;
logic [2:0] bpg;
logic [3:0] eff;
logic [1:0] base_in;
logic [3:0] wr_mask, wr_data;
logic seq_busy, bankable, ram_we;

always_comb begin
  case (cfg_reg.mode)
    `LCDW_MODE_STATIC: bpg = `LCDW_BPG_STATIC;
    `LCDW_MODE_MUX2: bpg = `LCDW_BPG_MUX2;
    `LCDW_MODE_MUX3: bpg = `LCDW_BPG_MUX3;
    default: bpg = `LCDW_BPG_MUX4;
  endcase
end

assign bankable = (cfg_reg.mode == `LCDW_MODE_STATIC) ||
                  (cfg_reg.mode == `LCDW_MODE_MUX2);
assign base_in = (in_bank_reg && bankable) ? `LCDW_ALT_BASE : 2'h0;
assign seq_busy = (seq_bits_reg != 4'h0);
assign sub_match = (sub_cnt_reg == strap_sub);
// the last 1:3 group carries two bits, leaving row two untouched
assign eff = (seq_bits_reg < {1'b0, bpg}) ? seq_bits_reg : {1'b0, bpg};
assign ram_we = seq_busy && sub_match && (ptr_reg <= `LCDW_RAM_LAST);

always_comb begin
  wr_mask = 4'h0;
  wr_data = 4'h0;
  for (int r = 0; r < 4; r++) begin
    if (r >= int'(base_in) && r < int'(base_in) + int'(eff)) begin
      wr_mask[r] = 1'b1;
      wr_data[r] = seq_sh_reg[7 - (r - int'(base_in))];
    end
  end
end

always_ff @(posedge sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    seq_sh_reg <= 8'h00;
    seq_bits_reg <= 4'h0;
  end else if (data_take) begin
    seq_sh_reg <= rx_byte;
    seq_bits_reg <= `LCDW_BYTE_BITS;
  end else if (seq_busy) begin
    seq_sh_reg <= seq_sh_reg << eff;
    seq_bits_reg <= seq_bits_reg - eff;
  end
end

// a byte is stored well inside one bit time, so no command can collide
always_ff @(posedge sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    ptr_reg <= 6'h00;
    sub_cnt_reg <= 3'h0;
  end else if (cmd_take && !rx_byte[6]) begin
    ptr_reg <= rx_byte[5:0];
  end else if (cmd_take && rx_byte[6:3] == `LCDW_OP_DEV) begin
    sub_cnt_reg <= rx_byte[2:0];
  end else if (seq_busy) begin
    if (ptr_reg >= `LCDW_RAM_LAST) begin
      ptr_reg <= 6'h00;
      sub_cnt_reg <= sub_cnt_reg + 3'h1;
    end else begin
      ptr_reg <= ptr_reg + 6'h1;
    end
  end
end

// display RAM carries no reset: its contents are data, not control
always_ff @(posedge sys_clk) begin
  if (ram_we) begin
    for (int r = 0; r < 4; r++) begin
      if (wr_mask[r]) begin
        ram_reg[ptr_reg][r] <= wr_data[r];
      end
    end
  end
end

assign ram_ptr = ptr_reg;
assign sub_cnt = sub_cnt_reg;

////////////////////////////////////////////////////////////////////////////
// blinker and output selector
logic [11:0] blink_cnt_reg, blink_half;
logic blink_ph_reg;
logic [$clog2(MUX_DIV)-1:0] mux_cnt_reg;
logic [1:0] row_cnt_reg, base_out, sel_row, row_use;
logic [`LCDW_RAM_WORDS-1:0] seg_reg;
logic [1:0] bp_reg;
logic disp_on_reg;

always_comb begin
  case (blink_reg.rate)
    2'h1: blink_half = `LCDW_BLINK_DIV1 >> 1;
    2'h2: blink_half = `LCDW_BLINK_DIV2 >> 1;
    2'h3: blink_half = `LCDW_BLINK_DIV3 >> 1;
    default: blink_half = 12'h000;
  endcase
end

always_ff @(posedge sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    blink_cnt_reg <= 12'h000;
    blink_ph_reg <= 1'b0;
  end else if (blink_reg.rate == 2'h0) begin
    blink_cnt_reg <= 12'h000;
    blink_ph_reg <= 1'b0;
  end else if (blink_cnt_reg >= blink_half - 12'h001) begin
    blink_cnt_reg <= 12'h000;
    blink_ph_reg <= ~blink_ph_reg;
  end else begin
    blink_cnt_reg <= blink_cnt_reg + 12'h001;
  end
end

assign base_out = ((out_bank_reg ^ (blink_reg.alt & blink_ph_reg)) &&
                   bankable) ? `LCDW_ALT_BASE : 2'h0;
// a mode change can leave the row step out of range for one cycle
assign row_use = ({1'b0, row_cnt_reg} >= bpg) ? 2'h0 : row_cnt_reg;
assign sel_row = base_out + row_use;

always_ff @(posedge sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    mux_cnt_reg <= '0;
    row_cnt_reg <= 2'h0;
  end else if (mux_cnt_reg == ($clog2(MUX_DIV))'(MUX_DIV - 1)) begin
    mux_cnt_reg <= '0;
    row_cnt_reg <= ({1'b0, row_cnt_reg} + 3'h1 >= bpg) ? 2'h0 :
                   row_cnt_reg + 2'h1;
  end else begin
    mux_cnt_reg <= mux_cnt_reg + 1'b1;
    if ({1'b0, row_cnt_reg} >= bpg) begin
      row_cnt_reg <= 2'h0;
    end
  end
end

always_ff @(posedge sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    seg_reg <= '0;
    bp_reg <= 2'h0;
    disp_on_reg <= 1'b0;
  end else begin
    for (int w = 0; w < `LCDW_RAM_WORDS; w++) begin
      seg_reg[w] <= ram_reg[w][sel_row];
    end
    bp_reg <= row_cnt_reg;
    disp_on_reg <= cfg_reg.en &
      ~((blink_reg.rate != 2'h0) & ~blink_reg.alt & blink_ph_reg);
  end
end

assign seg_data = seg_reg;
assign bp_sel = bp_reg;
assign disp_on = disp_on_reg;

////////////////////////////////////////////////////////////////////////////
// checks
sequence s_static_groups;
  seq_busy [*8] ##1 !seq_busy;
endsequence
property p_static_step;
  data_take && cfg_reg.mode == `LCDW_MODE_STATIC |=> s_static_groups;
endproperty
a_static_step: assert property (p_static_step)
  else $error("static byte not stored in eight steps");
property p_ptr_adv;
  seq_busy && ptr_reg < `LCDW_RAM_LAST |=> ptr_reg == $past(ptr_reg) + 6'h1;
endproperty
a_ptr_adv: assert property (p_ptr_adv)
  else $error("index did not advance by one word");
property p_wrap;
  seq_busy && ptr_reg == `LCDW_RAM_LAST |=>
    ptr_reg == 6'h00 && sub_cnt_reg == $past(sub_cnt_reg) + 3'h1;
endproperty
a_wrap: assert property (p_wrap)
  else $error("overflow did not wrap and bump subaddress");
property p_no_foreign;
  ram_we |-> sub_cnt_reg == strap_sub && seq_busy;
endproperty
a_no_foreign: assert property (p_no_foreign)
  else $error("write while subaddress differs");
property p_load_ptr;
  cmd_take && !rx_byte[6] |=> ptr_reg == $past(rx_byte[5:0]);
endproperty
a_load_ptr: assert property (p_load_ptr)
  else $error("index not loaded by command");
property p_ack_hold;
  ack_oe_reg && !scl_fall && !start_det && !stop_det |=> ack_oe_reg;
endproperty
a_ack_hold: assert property (p_ack_hold)
  else $error("acknowledge released before clock fell");
property p_only_ack;
  sda_oe |-> bit_cnt_reg == `LCDW_ACK_DRIVE && !sda_out;
endproperty
a_only_ack: assert property (p_only_ack)
  else $error("data line driven outside acknowledge");
property p_start;
  start_det |=> state_reg == ST_ADDR && bit_cnt_reg == 4'h0;
endproperty
a_start: assert property (p_start)
  else $error("start not recognised");
property p_foreign_addr;
  byte_done && state_reg == ST_ADDR &&
    rx_byte[7:1] != {`LCDW_SLAVE_HI, sa0_f} |=> state_reg == ST_SKIP;
endproperty
a_foreign_addr: assert property (p_foreign_addr)
  else $error("foreign address not skipped");
property p_blink1;
  blink_reg.rate == 2'h1 && $past(blink_reg.rate) == 2'h1 &&
    $changed(blink_ph_reg) |-> $past(blink_cnt_reg) == 12'h17f;
endproperty
a_blink1: assert property (p_blink1)
  else $error("blink mode one half period wrong");
property p_static_bank;
  cfg_reg.mode == `LCDW_MODE_STATIC && !blink_reg.alt |->
    sel_row == (out_bank_reg ? `LCDW_ALT_BASE : 2'h0);
endproperty
a_static_bank: assert property (p_static_bank)
  else $error("static output bank wrong");
property p_in_bank;
  seq_busy && cfg_reg.mode == `LCDW_MODE_STATIC && in_bank_reg |->
    wr_mask == 4'h4;
endproperty
a_in_bank: assert property (p_in_bank)
  else $error("static input bank wrong");
endmodule

// File: lcdw_master_model.sv
`timescale 1ns/100ps
// two-wire bus controller; lines only move just after a core clock edge
module lcdw_master_model (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // each line phase well above the two-cycle minimum of the receiver
  localparam int PH = 10;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // also serves as repeated start; lines go high before the falling data
  task automatic do_start();
    sda_drv <= 1'b1;
    hold(PH);
    scl <= 1'b1;
    hold(PH);
    sda_drv <= 1'b0;
    hold(PH);
    scl <= 1'b0;
    hold(PH);
  endtask

  task automatic do_stop();
    sda_drv <= 1'b0;
    hold(PH);
    scl <= 1'b1;
    hold(PH);
    sda_drv <= 1'b1;
    hold(PH);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // data changes only while the clock is low
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv <= b[i];
      hold(PH);
      scl <= 1'b1;
      hold(PH);
      scl <= 1'b0;
      hold(PH);
    end
    sda_drv <= 1'b1;
    hold(PH);
    scl <= 1'b1;
    hold(PH / 2);
    ack = ~sda_line;
    hold(PH / 2);
    scl <= 1'b0;
    hold(PH);
  endtask
endmodule

// File: testbench.sv
`timescale 1ns/100ps
`include "lcdw_defines.svh"
module testbench;
  import lcdw_pkg::*;
  logic sys_clk, rst_n, sa0_strap, sda_out, sda_oe, disp_on, ibank;
  logic m_scl, m_sda;
  logic [2:0] strap, sub_cnt;
  logic [39:0] seg_data, row0, row2, known0, known2;
  logic [1:0] bp_sel;
  logic [5:0] ram_ptr;
  logic [7:0] addr_w;
  lcdw_cfg_s drive_cfg;
  wire logic sda_line;
  int n_errors, checks, ptr, sub, n, mx;
  logic [1:0] modes [4];
  // open-drain data line with pull-up
  assign sda_line = m_sda & ~(sda_oe & ~sda_out);
  assign addr_w = {`LCDW_SLAVE_HI, sa0_strap, 1'b0};

  lcdw_top #(.MUX_DIV(4)) i_lcdw_top (.sys_clk(sys_clk), .rst_n(rst_n),
    .scl_in(m_scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .sa0_strap(sa0_strap),
    .strap_sub_bit0(strap[0]), .strap_sub_bit1(strap[1]),
    .strap_sub_bit2(strap[2]), .seg_data(seg_data), .bp_sel(bp_sel),
    .disp_on(disp_on), .drive_cfg(drive_cfg), .ram_ptr(ram_ptr),
    .sub_cnt(sub_cnt));
  lcdw_master_model i_lcdw_master_model (.sys_clk(sys_clk),
    .sda_line(sda_line), .scl(m_scl), .sda_drv(m_sda));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic send(input logic [7:0] b, input logic ea, input bit ck);
    logic a;
    i_lcdw_master_model.wr_byte(b, a);
    if (ck)
      chk(40'(a), 40'(ea));
  endtask

  task automatic cmd(input logic [7:0] c);
    i_lcdw_master_model.do_start();
    send(addr_w, 1'b1, 1'b1);
    send(c, 1'b1, 1'b1);
    i_lcdw_master_model.do_stop();
  endtask

  task automatic begin_xfer(input logic [1:0] m, input int a,
                            input logic [7:0] bk, input int p);
    i_lcdw_master_model.do_start();
    send(addr_w, 1'b1, 1'b1);
    send({4'hc, 2'b10, m}, 1'b1, 1'b1);
    send({5'h1c, 3'(a)}, 1'b1, 1'b1);
    send(bk, 1'b1, 1'b1);
    send({2'b00, 6'(p)}, 1'b1, 1'b1);
    ptr = p;
    sub = a % 8;
    ibank = bk[1];
  endtask

  // reference store: first bit of each group lands in row 0 or row 2
  task automatic data(input logic [1:0] m, input logic [7:0] b);
    int st, s0, g;
    st = (m == `LCDW_MODE_STATIC) ? 8 : (m == `LCDW_MODE_MUX2) ? 4 :
         (m == `LCDW_MODE_MUX3) ? 3 : 2;
    g = (m == `LCDW_MODE_STATIC) ? 1 : (m == `LCDW_MODE_MUX2) ? 2 :
        (m == `LCDW_MODE_MUX3) ? 3 : 4;
    s0 = sub;
    for (int i = 0; i < st; i++) begin
      if (sub == strap && ibank && g < 3) begin
        row2[ptr] = b[7-i*g];
        known2[ptr] = 1'b1;
      end else if (sub == strap) begin
        row0[ptr] = b[7-i*g];
        known0[ptr] = 1'b1;
      end
      ptr++;
      if (ptr > 39) begin
        ptr = 0;
        sub = (sub + 1) % 8;
      end
    end
    // ack only judged when the counter stays put within the byte
    send(b, s0 == strap, s0 == sub);
    chk(40'(ram_ptr), 40'(ptr));
    chk(40'(sub_cnt), 40'(sub));
  endtask

  // counts cycles from the previous rise, sampled away from the clock edge
  task automatic wait_rise(output int k);
    logic p;
    k = 1;
    p = disp_on;
    @(negedge sys_clk);
    while (!(disp_on === 1'b1 && p === 1'b0) && k < 8000) begin
      p = disp_on;
      @(negedge sys_clk);
      k++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (80000) @(posedge sys_clk);
    n_errors++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    sa0_strap = 1'b0;
    strap = 3'h0;
    {n_errors, checks, ptr, sub} = '0;
    {row0, row2, known0, known2, ibank} = '0;
    modes = '{`LCDW_MODE_STATIC, `LCDW_MODE_MUX2, `LCDW_MODE_MUX3,
              `LCDW_MODE_MUX4};
    n = $urandom(32'h0c00d7db);
    @(posedge sys_clk);
    sa0_strap <= 1'($urandom);
    strap <= 3'($urandom);
    repeat (9) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({sda_oe, drive_cfg, 26'h0, ram_ptr, sub_cnt}, 40'h0);
    // foreign address and read request stay silent
    i_lcdw_master_model.do_start();
    send({`LCDW_SLAVE_HI, ~sa0_strap, 1'b0}, 1'b0, 1'b1);
    i_lcdw_master_model.do_start();
    send({`LCDW_SLAVE_HI, sa0_strap, 1'b1}, 1'b0, 1'b1);
    i_lcdw_master_model.do_stop();
    // known word block, then overflow into a mismatched subaddress
    begin_xfer(`LCDW_MODE_STATIC, strap, 8'hf8, 4);
    data(`LCDW_MODE_STATIC, 8'($urandom));
    begin_xfer(`LCDW_MODE_STATIC, strap, 8'hf8, 36);
    data(`LCDW_MODE_STATIC, 8'($urandom));
    data(`LCDW_MODE_STATIC, 8'($urandom));
    i_lcdw_master_model.do_stop();
    chk(seg_data & known0, row0 & known0);
    begin_xfer(`LCDW_MODE_STATIC, strap, 8'hfa, 16);
    data(`LCDW_MODE_STATIC, 8'($urandom));
    i_lcdw_master_model.do_stop();
    chk(seg_data & known0, row0 & known0);
    cmd(8'h79);
    repeat (4) @(posedge sys_clk);
    chk(seg_data & known2, row2 & known2);
    cmd(8'h78);
    // alternate-bank blink: each bank shown for half of every period
    cmd(8'h75);
    n = 0;
    mx = 0;
    repeat (768) begin
      @(negedge sys_clk);
      if ((seg_data & known0) === (row0 & known0))
        n++;
      if ((seg_data & known2) === (row2 & known2))
        mx++;
    end
    chk(40'(n), 40'h180);
    chk(40'(mx), 40'h180);
    cmd(8'h70);
    // every drive mode crossing the last word, then a foreign subaddress
    foreach (modes[j]) begin
      begin_xfer(modes[j], strap, 8'hf8, 38);
      repeat (3) data(modes[j], 8'($urandom));
      i_lcdw_master_model.do_stop();
      mx = 0;
      repeat (64) begin
        @(posedge sys_clk);
        if (int'(bp_sel) > mx)
          mx = int'(bp_sel);
      end
      chk(40'(mx), 40'((modes[j] == 2'h0) ? 3 : modes[j] - 1));
      begin_xfer(modes[j], (strap + 1) % 8, 8'hf8, 0);
      data(modes[j], 8'($urandom));
      i_lcdw_master_model.do_stop();
    end
    // 1:4 elements blink singly only by rewriting their words; then whole-display blink rates in 1:4
    repeat (2) begin
      begin_xfer(`LCDW_MODE_MUX4, strap, 8'hf8, 20);
      data(`LCDW_MODE_MUX4, 8'($urandom));
      i_lcdw_master_model.do_stop();
      @(negedge sys_clk);
      while (bp_sel !== 2'h0)
        @(negedge sys_clk);
      chk(seg_data & known0, row0 & known0);
    end
    for (int r = 1; r < 4; r++) begin
      cmd(8'(8'h70 | r));
      wait_rise(n);
      wait_rise(n);
      chk(40'(n), 40'(768 << (r - 1)));
    end
    cmd(8'h70);
    // whole-display blink by hand through the enable bit
    cmd(8'h40);
    chk(40'({disp_on, drive_cfg}), 40'h0);
    cmd(8'h48);
    chk(40'({disp_on, drive_cfg}), 40'h18);
    mx = 0;
    repeat (4000) begin
      @(posedge sys_clk);
      if (disp_on !== 1'b1)
        mx++;
    end
    chk(40'(mx), 40'h0);
    print_verdict();
  end
endmodule
